// >>> lcd_port_pkg.sv
// Operation
// - Enable bit turns port3 lines into strobe, select
// - Two-bit field stretches each bus access
// - Codes give 4.5/11, 3.5/9, 2.5/6, 1.5/3 plus 0.5
// - Command store makes one command write cycle
// - Command load makes one command read cycle
// - Data store/load make data write/read cycles
// - Command and data windows eight bits, reset zero
// - Enable and timing field reset to zero
package lcd_port_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [15:0] CTRL_ADDR = 16'h100D;
  localparam logic [15:0] CMD_ADDR = 16'h100E;
  localparam logic [15:0] DATA_ADDR = 16'h100F;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SPEED_LO = 1;
  localparam int CTRL_SPEED_HI = 2;

  // ****************************************
  // Phase lengths in half CPU clocks
  // ****************************************
  // Half clocks keep the 0.5 parts; the timer rounds each up to a whole CPU clock.
  localparam logic [4:0] SETUP_HALF_0 = 5'h09;
  localparam logic [4:0] SETUP_HALF_1 = 5'h07;
  localparam logic [4:0] SETUP_HALF_2 = 5'h05;
  localparam logic [4:0] SETUP_HALF_3 = 5'h03;
  localparam logic [4:0] ACCESS_HALF_0 = 5'h16;
  localparam logic [4:0] ACCESS_HALF_1 = 5'h12;
  localparam logic [4:0] ACCESS_HALF_2 = 5'h0C;
  localparam logic [4:0] ACCESS_HALF_3 = 5'h06;
  localparam logic [4:0] HOLD_HALF = 5'h01;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_ACCESS = 2'b10,
    ST_HOLD = 2'b11
  } bus_state_t;

endpackage

// >>> phase_timer.sv
`timescale 1ns/100ps
// Counts half clocks of one phase; reports done on its last count.
module phase_timer
  import lcd_port_pkg::*;
#(
  parameter int W = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] half_count,
  output logic done
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  // Each core cycle removes two half clocks; a remainder of one still takes a whole cycle.
  always_comb begin
    if (load) begin
      count_next = half_count;
    end else if (count_reg > W'(2)) begin
      count_next = count_reg - W'(2);
    end else begin
      count_next = '0;
    end
  end

  // Registers the remaining half clocks.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  // Done looks only at the count, since the sequencer reloads on done.
  assign done = (count_reg <= W'(2));

endmodule

// >>> lcd_module_bus_port.sv
`timescale 1ns/100ps
module lcd_module_bus_port
  import lcd_port_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // CPU register access
  input wire logic [15:0] CPU_ADDR,
  input wire logic CPU_WR,
  input wire logic CPU_RD,
  input wire logic [7:0] CPU_WDATA,
  output logic [7:0] CPU_RDATA,
  output logic CPU_WAIT,
  // General port 3 lines 1 and 0 when interface is off
  input wire logic PORT3_LINE_ONE_GPIO,
  input wire logic PORT3_LINE_ZERO_GPIO,
  // Display bus pins
  output logic PORT3_LINE_ONE,
  output logic PORT3_LINE_ZERO,
  input wire logic [7:0] DISPLAY_DATA_IN,
  output logic [7:0] DISPLAY_DATA_OUT,
  output logic DISPLAY_DATA_OE,
  output logic DISPLAY_IS_DATA
);

  logic [2:0] ctrl_reg, ctrl_next;
  logic [7:0] cmd_reg, cmd_next;
  logic [7:0] data_reg, data_next;
  bus_state_t state_reg, state_next;
  logic rd_reg, rd_next;
  logic is_data_reg, is_data_next;
  logic strobe_reg, strobe_next;
  logic select_reg, select_next;
  logic oe_reg, oe_next;
  logic [7:0] dout_reg, dout_next;
  logic [7:0] rdata_reg, rdata_next;
  logic wait_reg, wait_next;
  logic [4:0] setup_half, access_half, load_half;
  logic timer_load, timer_done, win_hit;

  // ****************************************
  // Timing selection
  // ****************************************
  // The speed field picks set-up and access lengths; hold is fixed.
  always_comb begin
    case (ctrl_reg[CTRL_SPEED_HI:CTRL_SPEED_LO])
      2'b00: begin
        setup_half = SETUP_HALF_0;
        access_half = ACCESS_HALF_0;
      end
      2'b01: begin
        setup_half = SETUP_HALF_1;
        access_half = ACCESS_HALF_1;
      end
      2'b10: begin
        setup_half = SETUP_HALF_2;
        access_half = ACCESS_HALF_2;
      end
      default: begin
        setup_half = SETUP_HALF_3;
        access_half = ACCESS_HALF_3;
      end
    endcase
  end

  phase_timer #(
    .W(5)
  ) u_timer (
    .clk(CORE_CLK),
    .rst_n(RSTN),
    .load(timer_load),
    .half_count(load_half),
    .done(timer_done)
  );

  // Flags an access to either display window.
  assign win_hit = (CPU_ADDR == CMD_ADDR) || (CPU_ADDR == DATA_ADDR);

  // ****************************************
  // Register file and bus sequencer
  // ****************************************
  // Window accesses with the interface enabled run a full display cycle while the CPU is held off.
  always_comb begin
    ctrl_next = ctrl_reg;
    cmd_next = cmd_reg;
    data_next = data_reg;
    state_next = state_reg;
    rd_next = rd_reg;
    is_data_next = is_data_reg;
    strobe_next = strobe_reg;
    select_next = select_reg;
    oe_next = oe_reg;
    dout_next = dout_reg;
    rdata_next = rdata_reg;
    wait_next = wait_reg;
    timer_load = 1'b0;
    load_half = setup_half;
    case (state_reg)
      ST_IDLE: begin
        wait_next = 1'b0;
        strobe_next = 1'b0;
        oe_next = 1'b0;
        if (CPU_WR && (CPU_ADDR == CTRL_ADDR)) begin
          ctrl_next = CPU_WDATA[2:0];
        end else if (CPU_RD && (CPU_ADDR == CTRL_ADDR)) begin
          rdata_next = {5'h00, ctrl_reg};
        end else if ((CPU_WR || CPU_RD) && win_hit && ctrl_reg[CTRL_EN_BIT]) begin
          // Select and data settle first; strobe rises after set-up.
          rd_next = CPU_RD;
          is_data_next = (CPU_ADDR == DATA_ADDR);
          select_next = CPU_RD;
          oe_next = CPU_WR;
          if (CPU_WR && (CPU_ADDR == DATA_ADDR)) begin
            data_next = CPU_WDATA;
          end else if (CPU_WR) begin
            cmd_next = CPU_WDATA;
          end
          dout_next = CPU_WDATA;
          wait_next = 1'b1;
          timer_load = 1'b1;
          state_next = ST_SETUP;
        end else if (CPU_RD && win_hit) begin
          // Disabled interface: windows act as plain storage.
          rdata_next = (CPU_ADDR == DATA_ADDR) ? data_reg : cmd_reg;
        end else if (CPU_WR && (CPU_ADDR == DATA_ADDR)) begin
          data_next = CPU_WDATA;
        end else if (CPU_WR && (CPU_ADDR == CMD_ADDR)) begin
          cmd_next = CPU_WDATA;
        end
      end
      ST_SETUP: begin
        if (timer_done) begin
          strobe_next = 1'b1;
          timer_load = 1'b1;
          load_half = access_half;
          state_next = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        if (timer_done) begin
          strobe_next = 1'b0;
          timer_load = 1'b1;
          load_half = HOLD_HALF;
          state_next = ST_HOLD;
          if (rd_reg) begin
            // Sample read data at the strobe's falling edge.
            if (is_data_reg) begin
              data_next = DISPLAY_DATA_IN;
            end else begin
              cmd_next = DISPLAY_DATA_IN;
            end
            rdata_next = DISPLAY_DATA_IN;
          end
        end
      end
      ST_HOLD: begin
        if (timer_done) begin
          oe_next = 1'b0;
          select_next = 1'b0;
          wait_next = 1'b0;
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Registers the control, window and sequencer state.
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      ctrl_reg <= 3'h0;
      cmd_reg <= REG_RESET;
      data_reg <= REG_RESET;
      state_reg <= ST_IDLE;
      rd_reg <= 1'b0;
      is_data_reg <= 1'b0;
      strobe_reg <= 1'b0;
      select_reg <= 1'b0;
      oe_reg <= 1'b0;
      dout_reg <= 8'h00;
      rdata_reg <= 8'h00;
      wait_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      cmd_reg <= cmd_next;
      data_reg <= data_next;
      state_reg <= state_next;
      rd_reg <= rd_next;
      is_data_reg <= is_data_next;
      strobe_reg <= strobe_next;
      select_reg <= select_next;
      oe_reg <= oe_next;
      dout_reg <= dout_next;
      rdata_reg <= rdata_next;
      wait_reg <= wait_next;
    end
  end

  // ****************************************
  // Pin multiplexing
  // ****************************************
  // Port lines carry general data unless the interface is enabled.
  logic p1_reg, p0_reg, p1_next, p0_next;
  always_comb begin
    p1_next = ctrl_next[CTRL_EN_BIT] ? strobe_next : PORT3_LINE_ONE_GPIO;
    p0_next = ctrl_next[CTRL_EN_BIT] ? select_next : PORT3_LINE_ZERO_GPIO;
  end

  // Registers the pin values.
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      p1_reg <= 1'b0;
      p0_reg <= 1'b0;
    end else begin
      p1_reg <= p1_next;
      p0_reg <= p0_next;
    end
  end

  // Outputs come straight from registers.
  assign PORT3_LINE_ONE = p1_reg;
  assign PORT3_LINE_ZERO = p0_reg;
  assign DISPLAY_DATA_OUT = dout_reg;
  assign DISPLAY_DATA_OE = oe_reg;
  assign DISPLAY_IS_DATA = is_data_reg;
  assign CPU_RDATA = rdata_reg;
  assign CPU_WAIT = wait_reg;

endmodule

// >>> lcd_port_asserts.sv
`timescale 1ns/100ps
// ***
// Display bus port checker
// ***
module lcd_port_asserts
  import lcd_port_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RSTN,
  // CPU side
  input wire logic [15:0] CPU_ADDR,
  input wire logic CPU_WR,
  input wire logic CPU_RD,
  input wire logic [7:0] CPU_WDATA,
  input wire logic CPU_WAIT,
  // Pin side
  input wire logic PORT3_LINE_ONE_GPIO,
  input wire logic PORT3_LINE_ZERO_GPIO,
  input wire logic PORT3_LINE_ONE,
  input wire logic PORT3_LINE_ZERO,
  input wire logic DISPLAY_DATA_OE,
  input wire logic DISPLAY_IS_DATA
);
  // Shadow fields are {strobe width, data window, read, speed, enable}.
  logic [8:0] st_reg, st_next;
  logic [3:0] acc;
  logic take;
  // A request is taken only while no bus cycle runs.
  assign take = !CPU_WAIT && (CPU_WR || CPU_RD);
  assign acc = st_reg[2:1] == 2'h0 ? 4'hB : st_reg[2:1] == 2'h1 ? 4'h9 :
               st_reg[2:1] == 2'h2 ? 4'h6 : 4'h3;
  // Follows the control register, the access kind and the strobe width.
  always_comb begin
    st_next = st_reg;
    st_next[8:5] = PORT3_LINE_ONE ? st_reg[8:5] + 4'h1 : 4'h0;
    if (take) begin
      st_next[4:3] = {CPU_ADDR == DATA_ADDR, CPU_RD};
    end
    if (take && CPU_WR && CPU_ADDR == CTRL_ADDR) begin
      st_next[2:0] = CPU_WDATA[2:0];
    end
  end
  // Registers the shadow.
  always_ff @(posedge CORE_CLK) begin
    st_reg <= RSTN ? st_next : 9'h000;
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  sequence win_take;
    take && st_reg[0] && (CPU_ADDR == CMD_ADDR || CPU_ADDR == DATA_ADDR);
  endsequence
  sequence busy_rise;
    CPU_WAIT && $rose(PORT3_LINE_ONE);
  endsequence
  chk_wait_raise: assert property (
    win_take |=> CPU_WAIT) else $error("no wait");
  chk_ctrl_quick: assert property (
    take && CPU_ADDR == CTRL_ADDR |=> !CPU_WAIT) else $error("ctrl wait");
  chk_wait_span: assert property (
    win_take |=> CPU_WAIT [*5] ##[1:25] !CPU_WAIT) else $error("wait span");
  chk_strobe_width: assert property (
    CPU_WAIT && $fell(PORT3_LINE_ONE) |-> st_reg[8:5] == acc) else $error("width");
  chk_sel_first: assert property (
    busy_rise |-> $stable(PORT3_LINE_ZERO) && PORT3_LINE_ZERO == st_reg[3])
    else $error("select");
  chk_drive_dir: assert property (
    CPU_WAIT && PORT3_LINE_ONE |-> DISPLAY_DATA_OE == !st_reg[3]) else $error("oe");
  chk_window_kind: assert property (
    CPU_WAIT && PORT3_LINE_ONE |-> DISPLAY_IS_DATA == st_reg[4]) else $error("kind");
  chk_strobe_idle: assert property (
    st_reg[0] && $past(st_reg[0]) && !CPU_WAIT |-> !PORT3_LINE_ONE) else $error("idle");
  chk_gpio_pass: assert property (
    !st_reg[0] && !$past(st_reg[0]) && $past(RSTN) |->
      PORT3_LINE_ONE == $past(PORT3_LINE_ONE_GPIO) &&
      PORT3_LINE_ZERO == $past(PORT3_LINE_ZERO_GPIO)) else $error("gpio");
endmodule

bind lcd_module_bus_port lcd_port_asserts u_lcd_port_asserts (.*);

// >>> lcd_panel_model.sv
`timescale 1ns/100ps
// ***
// Display module model
// ***
module lcd_panel_model (
  // Clock
  input wire logic clk,
  // Display bus
  input wire logic strobe,
  input wire logic read_sel,
  input wire logic is_data,
  input wire logic [7:0] dout,
  output logic [7:0] din
);
  logic [7:0] mem [2] = '{8'h00, 8'h00};
  logic [7:0] last = 8'h5A;
  // Answers inverted stored bytes only during a read strobe, else churns.
  assign din = (strobe && read_sel) ? ~mem[is_data] : ~last;
  // Stores written bytes per window.
  always @(posedge clk) begin
    last <= din;
    if (strobe && !read_sel) begin
      mem[is_data] <= dout;
    end
  end
endmodule

// >>> tb_top.sv
`timescale 1ns/100ps
// ***
// Display bus port testbench
// ***
module tb_top;
  import lcd_port_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic cpu_wr = 1'b0;
  logic cpu_rd = 1'b0;
  logic g1 = 1'b0;
  logic g0 = 1'b0;
  logic en_tb = 1'b0;
  logic [15:0] cpu_addr = 16'h0000;
  logic [15:0] a;
  logic [7:0] cpu_wdata = 8'h00;
  logic [7:0] rdata, din, dout, rd_val, wb, bt;
  logic wt, p1, p0, oe, isd;
  logic [1:0] bs;
  logic [3:0] hi = 4'h0;
  logic [3:0] acc_tab [4] = '{4'hB, 4'h9, 4'h6, 4'h3};
  logic [13:0] exp_q [$];
  int err_count = 0;
  int num_checks = 0;
  int unsigned rnd;
  // Core clock.
  always #4 core_clk = ~core_clk;
  lcd_module_bus_port u_lcd_module_bus_port (
    .CORE_CLK(core_clk), .RSTN(rstn), .CPU_ADDR(cpu_addr), .CPU_WR(cpu_wr),
    .CPU_RD(cpu_rd), .CPU_WDATA(cpu_wdata), .CPU_RDATA(rdata), .CPU_WAIT(wt),
    .PORT3_LINE_ONE_GPIO(g1), .PORT3_LINE_ZERO_GPIO(g0), .PORT3_LINE_ONE(p1),
    .PORT3_LINE_ZERO(p0), .DISPLAY_DATA_IN(din), .DISPLAY_DATA_OUT(dout),
    .DISPLAY_DATA_OE(oe), .DISPLAY_IS_DATA(isd));
  lcd_panel_model u_lcd_panel_model (.clk(core_clk), .strobe(p1), .read_sel(p0),
    .is_data(isd), .dout(dout), .din(din));
  // Compares and counts.
  task automatic check(input logic [13:0] got, input logic [13:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic summarize();
    $display("Checks %0d, errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // One CPU access, held until the wait is released.
  task automatic cpu(input logic rd, input logic [15:0] ad, input logic [7:0] d);
    int n = 0;
    {cpu_rd, cpu_wr, cpu_addr, cpu_wdata} = {rd, !rd, ad, d};
    @(posedge core_clk);
    #1;
    while (wt !== 1'b0 && n < 40) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (wt !== 1'b0) begin
      err_count++;
      summarize();
    end
    rd_val = rdata;
    {cpu_rd, cpu_wr} = 2'b00;
    @(posedge core_clk);
    #1;
  endtask
  // Measures each strobe pulse and compares it with the oldest note.
  always @(posedge core_clk) begin
    if (p1 === 1'b1 && en_tb) begin
      hi <= hi + 4'h1;
      bt <= p0 ? din : dout;
      bs <= {p0, isd};
    end else if (hi != 4'h0) begin
      hi <= 4'h0;
      check({hi, bs, bt}, exp_q.size() > 0 ? exp_q.pop_front() : 14'h0000);
    end
  end
  // Main sequence.
  initial begin
    rnd = $urandom(51719);
    repeat (8) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    for (int i = 0; i < 3; i++) begin
      cpu(1'b1, CTRL_ADDR + 16'(i), 8'h00);
      check({6'h00, rd_val}, 14'h0000);
    end
    for (int k = 0; k < 2; k++) begin
      a = k ? DATA_ADDR : CMD_ADDR;
      wb = 8'($urandom);
      cpu(1'b0, a, wb);
      cpu(1'b1, a, 8'h00);
      check({6'h00, rd_val}, {6'h00, wb});
    end
    for (int c = 0; c < 4; c++) begin
      cpu(1'b0, CTRL_ADDR, {5'h00, 2'(c), 1'b1});
      en_tb = 1'b1;
      cpu(1'b1, CTRL_ADDR, 8'h00);
      check({6'h00, rd_val}, {11'h000, 2'(c), 1'b1});
      for (int k = 0; k < 2; k++) begin
        a = k ? DATA_ADDR : CMD_ADDR;
        wb = 8'($urandom);
        exp_q.push_back({acc_tab[c], 1'b0, 1'(k), wb});
        cpu(1'b0, a, wb);
        exp_q.push_back({acc_tab[c], 1'b1, 1'(k), ~wb});
        cpu(1'b1, a, 8'h00);
        check({6'h00, rd_val}, {6'h00, ~wb});
      end
    end
    cpu(1'b0, CTRL_ADDR, 8'h00);
    en_tb = 1'b0;
    repeat (4) begin
      {g1, g0} = 2'($urandom);
      repeat (2) @(posedge core_clk);
      #1;
      check({12'h000, p1, p0}, {12'h000, g1, g0});
    end
    // A second reset with the interface enabled and the windows loaded.
    cpu(1'b0, CTRL_ADDR, 8'h07);
    rstn = 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    for (int i = 0; i < 3; i++) begin
      cpu(1'b1, CTRL_ADDR + 16'(i), 8'h00);
      check({6'h00, rd_val}, 14'h0000);
    end
    check(14'(exp_q.size()), 14'h0000);
    summarize();
  end
endmodule
